// ---- verilog/sfrpe_flash.sv ----
// Serial flash instruction sequencer with read, program and sector erase.
//
// Summary of operation
// - Read 03h: select low, code then 24 address bits, MSB first.
// - Code and address bits are sampled on rising serial clock edges.
// - Read data leaves on the output line at falling edges, MSB first.
// - Read address increments after every byte until select rises.
// - Reads arriving while busy are dropped; the running cycle continues.
// - Fast read 0Bh adds eight dummy clocks with input ignored.
// - Dual read 3Bh drives data on output and shared lines together.
// - Program 02h: address plus at least one byte, up to 256.
// - Program is refused unless the write latch flag is set.
// - Program data past the page end wraps and overwrites.
// - Program runs only if select rises on a byte boundary.
// - Select rise starts a timed program with busy set meanwhile.
// - Finishing a program clears the write latch flag.
// - Program is not executed when its start address is protected.
// - Sector erase 20h sets the addressed 4K sector to FFh.
// - Sector erase is refused unless the write latch flag is set.
// - Erase runs only if select rises right after the address.
// - Erase is timed with busy set, then clears busy and latch.
// - Erase of a protected area is not executed.
// - Write enable 06h sets the write latch flag.
// - An eight-bit status byte with busy and latch flag is readable.
`timescale 1ns/1ps
module sfrpe_flash #(
   parameter int unsigned TPP_CYCLES = sfrpe_pkg::TPP_CYC,
   parameter int unsigned TSE_CYCLES = sfrpe_pkg::TSE_CYC
) (
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire sfrpe_pkg::sfrpe_spi_in_t  spi_i,
   output sfrpe_pkg::sfrpe_spi_out_t      spi_o,
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [7:0]                wb_adr_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic [31:0]               wb_dat_i,
   output logic      [31:0]               wb_dat_o,
   output logic                           wb_ack_o
);
   import sfrpe_pkg::*;

   localparam int unsigned SECT_AW = $clog2(SECTOR_BYTES);
   logic [2:0]           pin_s;
   logic                 sclk_d_r, cs_d_r;
   sfrpe_state_t         st_r;
   logic [7:0]           cmd_r;
   logic [7:0]           sin_r;
   logic [4:0]           bitc_r;
   logic [23:0]          addr_r;
   logic                 dual_r, stat_r, got_byte_r;
   logic [7:0]           poff_r;
   logic [7:0]           pbuf_r [0:PAGE_BYTES-1];
   logic [PAGE_BYTES-1:0] pval_r;
   logic [7:0]           mem_r [0:MEM_BYTES-1];
   logic [7:0]           out_sr_r;
   logic [2:0]           obit_r;
   logic [23:0]          raddr_r;
   logic                 so_r, so_oe_r, io_r, io_oe_r;
   logic                 busy_r;
   sfrpe_op_t            op_r;
   logic [31:0]          timer_r;
   logic [12:0]          work_r;
   logic                 wel_r;
   logic [3:0]           prot_r;
   logic                 ack_r;
   logic [31:0]          rdat_r;
   logic                 cs_act, cs_rise, sclk_rise, sclk_fall;
   logic [7:0]           sin_nxt;
   logic [23:0]          addr_nxt;
   logic                 addr_done, pbyte_done, start_prog, start_erase, set_wel;
   logic [31:0]          limit;
   logic                 cycle_end;
   logic [7:0]           byte_now;

   // Status byte as seen over the serial link and over Wishbone.
   function automatic logic [7:0] status_byte(input logic b, input logic w, input logic [3:0] p);
      logic [7:0] s;
      s = 8'h00;
      s[SR_BUSY] = b;
      s[SR_WEL] = w;
      s[SR_BP +: 3] = p[2:0];
      s[SR_TB] = p[3];
      return s;
   endfunction : status_byte

   // Protected span: top or bottom part of the array, doubling with each range step.
   function automatic logic prot_hit(input logic [MEM_AW-1:0] a, input logic [3:0] p);
      logic [MEM_AW-1:0] m;
      logic              hit;
      m = ~({MEM_AW{1'b1}} >> (3'h7 - p[2:0]));
      if (p[2:0] == 3'h0) begin
         hit = 1'b0;
      end else if (p[2:0] == 3'h7) begin
         hit = 1'b1;
      end else if (p[3]) begin
         hit = ((a & m) == '0);
      end else begin
         hit = ((a & m) == m);
      end
      return hit;
   endfunction : prot_hit

   // A sector that only partly overlaps the protected span must stay intact, so test its nearest end.
   function automatic logic sector_hit(input logic [MEM_AW-1:0] a, input logic [3:0] p);
      return prot_hit({a[MEM_AW-1:SECT_AW], {SECT_AW{~p[3]}}}, p);
   endfunction : sector_hit

   // Pins cross into the system clock before anything looks at them.
   sfrpe_sync #(
      .W   (3),
      .RST (SYNC_RESET)
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({spi_i.cs_n, spi_i.sclk, spi_i.sdi}),
      .q_o   (pin_s)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sclk_d_r <= 1'b0;
         cs_d_r   <= 1'b1;
      end else begin
         sclk_d_r <= pin_s[1];
         cs_d_r   <= pin_s[2];
      end
   end

   assign cs_act     = ~pin_s[2];
   assign cs_rise    = pin_s[2] & ~cs_d_r;
   assign sclk_rise  = cs_act & pin_s[1] & ~sclk_d_r;
   assign sclk_fall  = cs_act & ~pin_s[1] & sclk_d_r;
   assign sin_nxt    = {sin_r[6:0], pin_s[0]};
   assign addr_nxt   = {addr_r[22:0], pin_s[0]};
   assign addr_done  = sclk_rise && (st_r == ST_ADDR) && (bitc_r == ADDR_LAST_BIT);
   assign pbyte_done = sclk_rise && (st_r == ST_PROG) && (bitc_r == CMD_LAST_BIT);
   assign start_prog = cs_rise && (st_r == ST_PROG) && (bitc_r == 5'h00) && got_byte_r
                       && !prot_hit(addr_r[MEM_AW-1:0], prot_r);
   assign start_erase = cs_rise && (st_r == ST_ARMED)
                        && !sector_hit(addr_r[MEM_AW-1:0], prot_r);
   assign set_wel    = cs_rise && (st_r == ST_WREN);

   // Instruction, address and dummy phases, stepped on rising serial clock edges.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r       <= ST_CMD;
         cmd_r      <= 8'h00;
         sin_r      <= 8'h00;
         bitc_r     <= 5'h00;
         addr_r     <= 24'h000000;
         dual_r     <= 1'b0;
         stat_r     <= 1'b0;
         got_byte_r <= 1'b0;
      end else if (!cs_act) begin
         st_r       <= ST_CMD;
         bitc_r     <= 5'h00;
         got_byte_r <= 1'b0;
      end else if (sclk_rise) begin
         case (st_r)
            ST_CMD: begin
               sin_r  <= sin_nxt;
               bitc_r <= bitc_r + 5'h01;
               if (bitc_r == CMD_LAST_BIT) begin
                  bitc_r <= 5'h00;
                  cmd_r  <= sin_nxt;
                  dual_r <= (sin_nxt == CMD_DUAL);
                  stat_r <= (sin_nxt == CMD_RDSR);
                  if (busy_r && sin_nxt != CMD_RDSR) begin
                     st_r <= ST_IGNORE;
                  end else if (sin_nxt == CMD_RDSR) begin
                     st_r <= ST_DATA;
                  end else if (sin_nxt == CMD_WREN) begin
                     st_r <= ST_WREN;
                  end else if (sin_nxt == CMD_READ || sin_nxt == CMD_FAST || sin_nxt == CMD_DUAL) begin
                     st_r <= ST_ADDR;
                  end else if (sin_nxt == CMD_PROG || sin_nxt == CMD_SERASE) begin
                     st_r <= wel_r ? ST_ADDR : ST_IGNORE;
                  end else begin
                     st_r <= ST_IGNORE;
                  end
               end
            end
            ST_ADDR: begin
               addr_r <= addr_nxt;
               bitc_r <= bitc_r + 5'h01;
               if (bitc_r == ADDR_LAST_BIT) begin
                  bitc_r <= 5'h00;
                  case (cmd_r)
                     CMD_READ:   st_r <= ST_DATA;
                     CMD_FAST:   st_r <= ST_DUMMY;
                     CMD_DUAL:   st_r <= ST_DUMMY;
                     CMD_PROG:   st_r <= ST_PROG;
                     CMD_SERASE: st_r <= ST_ARMED;
                     default:    st_r <= ST_IGNORE;
                  endcase
               end
            end
            ST_DUMMY: begin
               bitc_r <= bitc_r + 5'h01;
               if (bitc_r == DUMMY_LAST) begin
                  bitc_r <= 5'h00;
                  st_r   <= ST_DATA;
               end
            end
            ST_PROG: begin
               sin_r  <= sin_nxt;
               bitc_r <= bitc_r + 5'h01;
               if (bitc_r == CMD_LAST_BIT) begin
                  bitc_r     <= 5'h00;
                  got_byte_r <= 1'b1;
               end
            end
            ST_ARMED: st_r <= ST_IGNORE;
            ST_WREN:  st_r <= ST_IGNORE;
            ST_DATA, ST_IGNORE: st_r <= st_r;
            default:  st_r <= ST_IGNORE;
         endcase
      end
   end

   // Page buffer: the byte offset wraps inside the page, so late bytes overwrite early ones.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         poff_r <= 8'h00;
         pval_r <= '0;
      end else if (addr_done) begin
         poff_r <= addr_nxt[7:0];
         pval_r <= '0;
      end else if (pbyte_done) begin
         pbuf_r[poff_r] <= sin_nxt;
         pval_r[poff_r] <= 1'b1;
         poff_r         <= poff_r + 8'h01;
      end
   end

   assign limit     = (op_r == OP_PROG) ? TPP_CYCLES : TSE_CYCLES;
   assign cycle_end = busy_r && (timer_r == limit - 32'h1);
   // Self-timed cycle; status reads stay possible throughout.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_r  <= 1'b0;
         op_r    <= OP_NONE;
         timer_r <= 32'h0;
         work_r  <= 13'h0000;
      end else if (start_prog || start_erase) begin
         busy_r  <= 1'b1;
         op_r    <= start_prog ? OP_PROG : OP_ERASE;
         timer_r <= 32'h0;
         work_r  <= 13'h0000;
      end else if (busy_r) begin
         timer_r <= timer_r + 32'h1;
         if (!work_r[12]) begin
            work_r <= work_r + 13'h0001;
         end
         if (cycle_end) begin
            busy_r <= 1'b0;
            op_r   <= OP_NONE;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wel_r <= 1'b0;
      end else if (set_wel) begin
         wel_r <= 1'b1;
      end else if (cycle_end) begin
         wel_r <= 1'b0;
      end
   end
   // Array updates run one byte per clock early in the cycle; the array is not reset.
   always_ff @(posedge clk_i) begin
      if (busy_r && op_r == OP_PROG && work_r < 13'h0100 && pval_r[work_r[7:0]]) begin
         mem_r[{addr_r[MEM_AW-1:8], work_r[7:0]}] <=
            mem_r[{addr_r[MEM_AW-1:8], work_r[7:0]}] & pbuf_r[work_r[7:0]];
      end else if (busy_r && op_r == OP_ERASE && !work_r[12]) begin
         mem_r[{addr_r[MEM_AW-1:12], work_r[11:0]}] <= 8'hFF;
      end
   end
   assign byte_now = (obit_r != 3'h0) ? out_sr_r :
                     stat_r ? status_byte(busy_r, wel_r, prot_r) : mem_r[raddr_r[MEM_AW-1:0]];
   // Output shifter, stepped on falling serial clock edges.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_sr_r <= 8'h00;
         obit_r   <= 3'h0;
         raddr_r  <= 24'h000000;
         so_r     <= 1'b0;
         so_oe_r  <= 1'b0;
         io_r     <= 1'b0;
         io_oe_r  <= 1'b0;
      end else if (!cs_act) begin
         obit_r  <= 3'h0;
         so_oe_r <= 1'b0;
         io_oe_r <= 1'b0;
      end else if (addr_done) begin
         raddr_r <= addr_nxt;
      end else if (sclk_fall && st_r == ST_DATA) begin
         so_oe_r <= 1'b1;
         so_r    <= byte_now[7];
         if (dual_r) begin
            io_r     <= byte_now[6];
            io_oe_r  <= 1'b1;
            out_sr_r <= {byte_now[5:0], 2'b00};
            obit_r   <= obit_r + 3'h2;
         end else begin
            out_sr_r <= {byte_now[6:0], 1'b0};
            obit_r   <= obit_r + 3'h1;
         end
         if ((dual_r && obit_r == 3'h6) || (!dual_r && obit_r == 3'h7)) begin
            raddr_r <= raddr_r + 24'h000001;
         end
      end
   end
   assign spi_o = '{so: so_r, so_oe: so_oe_r, io: io_r, io_oe: io_oe_r};
   // Wishbone slave: one wait state, writes land at the acknowledging edge.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r  <= 1'b0;
         rdat_r <= 32'h0;
         prot_r <= PROT_RESET;
      end else begin
         ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
         if (wb_cyc_i && wb_stb_i && !ack_r) begin
            case (wb_adr_i)
               REG_STATUS: rdat_r <= {24'h000000, status_byte(busy_r, wel_r, prot_r)};
               REG_PROT:   rdat_r <= {28'h0000000, prot_r};
               default:    rdat_r <= 32'h0;
            endcase
         end
         if (wb_cyc_i && wb_stb_i && ack_r && wb_we_i && wb_adr_i == REG_PROT && wb_sel_i[0]) begin
            prot_r <= wb_dat_i[3:0];
         end
      end
   end
   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   busy_no_read_a: assert property (!(busy_r && st_r == ST_DATA && !stat_r))
      else $error("Array read served while busy.");
   wel_gate_a: assert property ($rose(busy_r) |-> wel_r)
      else $error("Cycle started without write latch flag.");
   end_clears_wel_a: assert property ($fell(busy_r) |-> !wel_r)
      else $error("Write latch flag survived end of cycle.");
   prog_start_a: assert property (start_prog |=> busy_r && op_r == OP_PROG && timer_r == 32'h0)
      else $error("Program did not start on select rise.");
   page_wrap_a: assert property (pbyte_done |=> poff_r == $past(poff_r) + 8'h01)
      else $error("Page offset did not advance with wrap.");
   addr_step_a: assert property (sclk_fall && st_r == ST_DATA && !dual_r && obit_r == 3'h7
                                 |=> raddr_r == $past(raddr_r) + 24'h000001)
      else $error("Read address did not increment.");
   so_on_fall_a: assert property ($changed(so_r) |-> $past(sclk_fall))
      else $error("Output changed away from a falling edge.");
   io_dual_only_a: assert property (io_oe_r |-> dual_r)
      else $error("Shared line driven outside dual read.");
   erase_guard_a: assert property (start_erase |-> !sector_hit(addr_r[MEM_AW-1:0], prot_r) && wel_r)
      else $error("Erase started on protected area.");
   busy_hold_a: assert property ($rose(busy_r) |-> busy_r [*8])
      else $error("Busy dropped too early.");
   prog_seen_c:  cover property (start_prog);
   erase_seen_c: cover property (start_erase);
   dual_seen_c:  cover property (io_oe_r && sclk_fall);
   stat_busy_c:  cover property (busy_r && stat_r && st_r == ST_DATA && sclk_fall);
endmodule : sfrpe_flash

// ---- verilog/sfrpe_pkg.sv ----
// Constants and types shared by the serial flash sequencer.
package sfrpe_pkg;
   // Instruction codes.
   localparam logic [7:0] CMD_READ   = 8'h03;
   localparam logic [7:0] CMD_FAST   = 8'h0B;
   localparam logic [7:0] CMD_DUAL   = 8'h3B;
   localparam logic [7:0] CMD_PROG   = 8'h02;
   localparam logic [7:0] CMD_SERASE = 8'h20;
   localparam logic [7:0] CMD_WREN   = 8'h06;
   localparam logic [7:0] CMD_RDSR   = 8'h05;

   // Frame geometry.
   localparam logic [4:0] CMD_LAST_BIT  = 5'h07;
   localparam logic [4:0] ADDR_LAST_BIT = 5'h17;
   localparam logic [4:0] DUMMY_LAST    = 5'h07;
   localparam int unsigned PAGE_BYTES   = 256;
   localparam int unsigned SECTOR_BYTES = 4096;

   // Implemented array: the low address bits only, the upper bits alias.
   localparam int unsigned MEM_AW    = 13;
   localparam int unsigned MEM_BYTES = 8192;

   // Status byte layout.
   localparam int unsigned SR_BUSY = 0;
   localparam int unsigned SR_WEL  = 1;
   localparam int unsigned SR_BP   = 2;
   localparam int unsigned SR_TB   = 5;

   // Wishbone register byte addresses and reset values.
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_PROT   = 8'h04;
   localparam logic [3:0] PROT_RESET = 4'h0;
   localparam logic [2:0] SYNC_RESET = 3'h4;

   // Self-timed cycle durations.
   localparam int unsigned CLK_HZ   = 20000000;
   localparam int unsigned TPP_US   = 1000;
   localparam int unsigned TSE_US   = 10000;
   localparam int unsigned TPP_CYC  = TPP_US * (CLK_HZ / 1000000);
   localparam int unsigned TSE_CYC  = TSE_US * (CLK_HZ / 1000000);

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic sdi;
   } sfrpe_spi_in_t;

   typedef struct packed {
      logic so;
      logic so_oe;
      logic io;
      logic io_oe;
   } sfrpe_spi_out_t;

   typedef enum logic [2:0] {
      ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_PROG, ST_ARMED, ST_WREN, ST_IGNORE
   } sfrpe_state_t;

   typedef enum logic [1:0] {
      OP_NONE, OP_PROG, OP_ERASE
   } sfrpe_op_t;
endpackage : sfrpe_pkg

// ---- verilog/sfrpe_sync.sv ----
// Two-flop synchroniser for the serial pins.
`timescale 1ns/1ps
module sfrpe_sync #(
   parameter int unsigned     W   = 3,
   parameter logic [W-1:0]    RST = '0
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_r <= RST;
         q_o    <= RST;
      end else begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
endmodule : sfrpe_sync

// ---- dv/sfrpe_host.sv ----
// SPI host model that drives the flash's serial pins in mode 0.
`timescale 1ns/1ps
module sfrpe_host (
   input  wire logic clk_i,
   input  wire logic so_i,
   input  wire logic io_i,
   output logic      cs_n_o,
   output logic      sclk_o,
   output logic      sdi_o,
   output logic      sdi_oe_o
);
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o = 1'b0;
      sdi_oe_o = 1'b1;
   end

   task automatic half();
      repeat (4) @(posedge clk_i);
   endtask : half

   task automatic start();
      cs_n_o <= 1'b0;
      sdi_oe_o <= 1'b1;
      half();
   endtask : start

   // Select rises in the same step as the final clock fall, after whole bytes or after a partial byte.
   task automatic stop();
      cs_n_o <= 1'b1;
      sdi_o <= ~sdi_o;
      repeat (8) @(posedge clk_i);
   endtask : stop

   // Output is sampled late in the low phase, when the device has settled.
   task automatic clock_bit(input logic b, output logic so, output logic io);
      sdi_o <= b;
      half();
      so = so_i;
      io = io_i;
      sclk_o <= 1'b1;
      half();
      sclk_o <= 1'b0;
   endtask : clock_bit

   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      logic s;
      logic d;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(tx[i], s, d);
         rx[i] = s;
      end
   endtask : xfer

   // Host lets go of the shared line before the first data clock.
   task automatic xfer2(output logic [7:0] rx);
      logic s;
      logic d;
      sdi_oe_o <= 1'b0;
      for (int i = 3; i >= 0; i--) begin
         clock_bit(1'b0, s, d);
         rx[2*i+1] = s;
         rx[2*i] = d;
      end
   endtask : xfer2

   task automatic head(input logic [7:0] op, input logic [23:0] adr);
      logic [7:0] r;
      start();
      xfer(op, r);
      for (int k = 2; k >= 0; k--) begin
         xfer(adr[8*k +: 8], r);
      end
   endtask : head
endmodule : sfrpe_host

// ---- dv/sfrpe_flash_tb_top.sv ----
// Self-checking testbench for the serial flash sequencer.
`timescale 1ns/1ps
module sfrpe_flash_tb_top;
   import sfrpe_pkg::*;
   logic           clk = 1'b0;
   logic           rst = 1'b1;
   logic           cs_n, sclk, sdi_d, sdi_oe;
   sfrpe_spi_in_t  spi_in;
   sfrpe_spi_out_t spi_out;
   logic           wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
   logic [7:0]     wb_adr = 8'h00;
   logic [3:0]     wb_sel = 4'h0;
   logic [31:0]    wb_wdat = 32'h0, wb_rdat;
   int             n_errors = 0;
   int             n_compared = 0;

   always #25 clk = ~clk;
   // A released shared line shows the inverse of its last value, never a kind level.
   always_comb spi_in = '{cs_n: cs_n, sclk: sclk,
                          sdi: spi_out.io_oe ? spi_out.io : (sdi_oe ? sdi_d : ~sdi_d)};

   // The program cycle must outlast a status poll plus a whole refused read frame.
   sfrpe_flash #(.TPP_CYCLES(2000), .TSE_CYCLES(5000)) dut (
      .clk_i(clk), .rst_i(rst), .spi_i(spi_in), .spi_o(spi_out),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
   sfrpe_host u_host (
      .clk_i(clk), .so_i(spi_out.so_oe ? spi_out.so : ~spi_out.so), .io_i(spi_in.sdi), .cs_n_o(cs_n),
      .sclk_o(sclk), .sdi_o(sdi_d), .sdi_oe_o(sdi_oe));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test

   task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                           output logic [31:0] rd);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_wdat <= wd;
      wb_sel <= 4'hF;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      rd = wb_rdat;
      if (n >= 20) check(32'h0, 32'h1);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk);
   endtask : wb_cycle

   task automatic wb_check(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] rd;
      wb_cycle(1'b0, adr, 32'h0, rd);
      check(rd, exp);
   endtask : wb_check

   task automatic wb_write(input logic [7:0] adr, input logic [31:0] wd);
      logic [31:0] rd;
      wb_cycle(1'b1, adr, wd, rd);
   endtask : wb_write

   task automatic wait_idle();
      logic [31:0] rd;
      int n;
      n = 0;
      do begin
         wb_cycle(1'b0, REG_STATUS, 32'h0, rd);
         n++;
      end while (rd[SR_BUSY] !== 1'b0 && n < 3000);
      check(rd, 32'h0);
   endtask : wait_idle

   task automatic spi_cmd(input logic [7:0] op);
      logic [7:0] r;
      u_host.start();
      u_host.xfer(op, r);
      u_host.stop();
   endtask : spi_cmd

   task automatic read_chk(input logic [7:0] op, input logic [23:0] adr, input logic [23:0] exp);
      logic [7:0] r;
      u_host.head(op, adr);
      if (op != CMD_READ) u_host.xfer(8'hA5, r);
      for (int k = 2; k >= 0; k--) begin
         u_host.xfer(8'h00, r);
         check(r, exp[8*k +: 8]);
      end
      u_host.stop();
   endtask : read_chk

   task automatic t_regs();
      logic [7:0] r;
      wb_check(REG_STATUS, 32'h0);
      wb_check(REG_PROT, {28'h0, PROT_RESET});
      wb_write(REG_PROT, 32'h0000000F);
      wb_check(REG_PROT, 32'h0000000F);
      wb_check(REG_STATUS, 32'h0000003C);
      wb_check(8'h08, 32'h0);
      wb_write(REG_PROT, 32'h0);
      spi_cmd(CMD_WREN);
      u_host.start();
      u_host.xfer(CMD_RDSR, r);
      u_host.xfer(8'h00, r);
      check(r, 8'h02);
      u_host.stop();
      $display("Test registers done");
   endtask : t_regs

   task automatic t_erase_prog();
      logic [7:0] r;
      u_host.head(CMD_SERASE, 24'h001000);
      u_host.stop();
      wb_check(REG_STATUS, 32'h03);
      wait_idle();
      read_chk(CMD_READ, 24'h0010FE, 24'hFFFFFF);
      spi_cmd(CMD_WREN);
      u_host.head(CMD_PROG, 24'h0010FE);
      u_host.xfer(8'h11, r);
      u_host.xfer(8'h22, r);
      u_host.xfer(8'h33, r);
      u_host.stop();
      wb_check(REG_STATUS, 32'h03);
      u_host.head(CMD_READ, 24'h001000);
      u_host.xfer(8'h00, r);
      check(spi_out.so_oe, 1'b0);
      u_host.stop();
      wb_check(REG_STATUS, 32'h03);
      wait_idle();
      read_chk(CMD_FAST, 24'h0010FE, 24'h1122FF);
      read_chk(CMD_READ, 24'h001000, 24'h33FFFF);
      $display("Test erase and program done");
   endtask : t_erase_prog

   task automatic t_refuse();
      logic [7:0] r;
      logic s;
      logic d;
      u_host.head(CMD_PROG, 24'h001010);
      u_host.xfer(8'h44, r);
      u_host.stop();
      wb_check(REG_STATUS, 32'h0);
      spi_cmd(CMD_WREN);
      u_host.head(CMD_PROG, 24'h001010);
      u_host.xfer(8'h44, r);
      for (int i = 0; i < 3; i++) u_host.clock_bit(1'b0, s, d);
      u_host.stop();
      wb_check(REG_STATUS, 32'h02);
      spi_cmd(CMD_WREN);
      u_host.head(CMD_SERASE, 24'h001000);
      u_host.clock_bit(1'b0, s, d);
      u_host.stop();
      wb_check(REG_STATUS, 32'h02);
      wb_write(REG_PROT, 32'h1);
      u_host.head(CMD_PROG, 24'h001F80);
      u_host.xfer(8'h00, r);
      u_host.stop();
      wb_check(REG_STATUS, 32'h06);
      u_host.head(CMD_SERASE, 24'h001000);
      u_host.stop();
      wb_check(REG_STATUS, 32'h06);
      wb_write(REG_PROT, 32'h0);
      read_chk(CMD_READ, 24'h001010, 24'hFFFFFF);
      read_chk(CMD_READ, 24'h001F80, 24'hFFFFFF);
      $display("Test refusals done");
   endtask : t_refuse

   task automatic t_dual();
      logic [7:0] r;
      u_host.head(CMD_DUAL, 24'h0010FE);
      u_host.xfer(8'hA5, r);
      u_host.xfer2(r);
      check(r, 8'h11);
      check(spi_out.io_oe, 1'b1);
      u_host.xfer2(r);
      check(r, 8'h22);
      u_host.stop();
      check(spi_out.io_oe, 1'b0);
      $display("Test dual read done");
   endtask : t_dual

   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      end_of_test();
   end

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_regs();
      t_erase_prog();
      t_refuse();
      t_dual();
      end_of_test();
   end
endmodule : sfrpe_flash_tb_top
